// *** card_addr_decode.sv ***
// Address and strobe decoder, registered
`timescale 1ns/1ps
module card_addr_decode (
    // Clock and reset
    input  wire logic   i_core_clk,
    input  wire logic   i_reset,
    // Decode carrier
    card_decode_if.dec  bus
);

    card_pin_pkg::space_e space;
    card_pin_pkg::space_e next_space;
    logic [10:0]          index;
    logic [10:0]          next_index;
    logic                 rd;
    logic                 next_rd;
    logic                 wr;
    logic                 next_wr;
    logic                 wide;
    logic                 next_wide;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        next_space = card_pin_pkg::SPACE_NONE;
        next_index = '0;
        next_rd    = 1'b0;
        next_wr    = 1'b0;
        next_wide  = 1'b0;
        if (bus.mode == card_pin_pkg::MODE_DISK) begin
            // Only low three bits; write enable unused
            next_index = {8'h00, bus.addr[2:0]};
            next_rd    = !bus.iord_n;
            next_wr    = !bus.iowr_n;
            if (bus.dma_active) begin
                next_wide = 1'b1;
            end else if (!bus.first_sel_n) begin
                next_space = card_pin_pkg::SPACE_TASK;
            end else if (!bus.odd_sel_n) begin
                next_space = card_pin_pkg::SPACE_CTRL;
            end
        end else if (!bus.first_sel_n || !bus.odd_sel_n) begin
            // Full address with attribute select
            next_index = bus.addr;
            // Upper lane only when both selects driven low
            next_wide  = !bus.first_sel_n && !bus.odd_sel_n;
            if (!bus.attr_n && (!bus.oe_n || !bus.we_n)) begin
                next_space = (bus.addr >= card_pin_pkg::CONFIG_BASE)
                           ? card_pin_pkg::SPACE_CONFIG
                           : card_pin_pkg::SPACE_CIS;
                next_rd    = !bus.oe_n;
                next_wr    = !bus.we_n;
            end else if (bus.mode == card_pin_pkg::MODE_IO &&
                         (!bus.iord_n || !bus.iowr_n)) begin
                next_space = card_pin_pkg::SPACE_IOPORT;
                next_rd    = !bus.iord_n;
                next_wr    = !bus.iowr_n;
            end else if (bus.mode == card_pin_pkg::MODE_MEM &&
                         bus.attr_n && (!bus.oe_n || !bus.we_n)) begin
                next_space = card_pin_pkg::SPACE_MEMPORT;
                next_rd    = !bus.oe_n;
                next_wr    = !bus.we_n;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            space <= card_pin_pkg::SPACE_NONE;
            index <= '0;
            rd    <= 1'b0;
            wr    <= 1'b0;
            wide  <= 1'b0;
        end else begin
            space <= next_space;
            index <= next_index;
            rd    <= next_rd;
            wr    <= next_wr;
            wide  <= next_wide;
        end
    end

    assign bus.space = space;
    assign bus.index = index;
    assign bus.rd    = rd;
    assign bus.wr    = wr;
    assign bus.wide  = wide;

endmodule : card_addr_decode

// *** card_decode_if.sv ***
// Carrier between the pin top and its address decoder
`timescale 1ns/1ps
interface card_decode_if;
    card_pin_pkg::mode_e  mode;
    logic [10:0]          addr;
    logic                 first_sel_n;
    logic                 odd_sel_n;
    logic                 attr_n;
    logic                 oe_n;
    logic                 we_n;
    logic                 iord_n;
    logic                 iowr_n;
    logic                 dma_active;
    card_pin_pkg::space_e space;
    logic [10:0]          index;
    logic                 rd;
    logic                 wr;
    logic                 wide;

    modport top (output mode, addr, first_sel_n, odd_sel_n, attr_n, oe_n,
                 we_n, iord_n, iowr_n, dma_active,
                 input space, index, rd, wr, wide);
    modport dec (input mode, addr, first_sel_n, odd_sel_n, attr_n, oe_n,
                 we_n, iord_n, iowr_n, dma_active,
                 output space, index, rd, wr, wide);
endinterface : card_decode_if

// *** card_pin_pkg.sv ***
// Shared constants and types for the card host pin interface
package card_pin_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 11;
    localparam int TASK_IDX_W = 3;
    localparam int DATA_W     = 16;

    // ------------------------------------------------------------------
    // Address split and fixed pin levels
    // ------------------------------------------------------------------
    localparam logic [10:0] CONFIG_BASE   = 11'h200;
    localparam logic        DETECT_LEVEL  = 1'h0;
    localparam logic        BATTERY_LEVEL = 1'h1;
    localparam logic        AUDIO_NEGATED = 1'h1;

    // ------------------------------------------------------------------
    // Supported transfer modes
    // ------------------------------------------------------------------
    localparam logic [2:0] PIO_MODE_MAX = 3'h6;
    localparam logic [2:0] DMA_MODE_MAX = 3'h4;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MEM  = 2'h0,
        MODE_IO   = 2'h1,
        MODE_DISK = 2'h3
    } mode_e;

    typedef enum logic [2:0] {
        SPACE_NONE    = 3'h0,
        SPACE_TASK    = 3'h1,
        SPACE_CTRL    = 3'h3,
        SPACE_IOPORT  = 3'h2,
        SPACE_MEMPORT = 3'h6,
        SPACE_CIS     = 3'h7,
        SPACE_CONFIG  = 3'h5
    } space_e;

    typedef enum logic [1:0] {
        DMA_IDLE = 2'h0,
        DMA_REQ  = 2'h1,
        DMA_XFER = 2'h3
    } dma_e;

endpackage : card_pin_pkg

// *** host_dma_model.sv ***
// Host controller model that answers the card DMA request
`timescale 1ns/1ps
module host_dma_model (
    input  wire logic i_core_clk,
    input  wire logic i_dma_request,
    input  wire logic i_slow,
    output logic      o_dma_acknowledge_n
);
    initial begin
        o_dma_acknowledge_n = 1'h1;
        forever begin
            @(posedge i_core_clk);
            #1;
            if (i_dma_request && o_dma_acknowledge_n) begin
                repeat (i_slow ? 3 : 1) @(posedge i_core_clk);
                #1 o_dma_acknowledge_n = 1'h0;
            end else if (!i_dma_request) begin
                o_dma_acknowledge_n = 1'h1;
            end
        end
    end
endmodule : host_dma_model

// *** storage_card_host_pin_interface.sv ***
// Host pin interface of a flash storage card
`timescale 1ns/1ps
module storage_card_host_pin_interface #(
    parameter bit DMA_SUPPORTED = 1'b1
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // Host address and selects
    input  wire logic [10:0] i_addr,
    input  wire logic        i_command_block_select_n,
    input  wire logic        i_odd_byte_enable_n,
    input  wire logic        i_output_enable_n,
    input  wire logic        i_disk_mode_select_n,
    input  wire logic        i_attr_dma_acknowledge_n,
    input  wire logic        i_io_read_n,
    input  wire logic        i_io_write_n,
    input  wire logic        i_write_enable_n,
    input  wire logic        i_primary_secondary_select_n,
    // Host data
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic             o_data_low_oe,
    output logic             o_data_high_oe,
    // Fixed and status pins
    output logic             o_battery_detect_first,
    output logic             o_battery_detect_second,
    output logic             o_status_change_alert_n,
    output logic             o_audio_out_n,
    output logic             o_insert_detect_first_n,
    output logic             o_insert_detect_second_n,
    // Shared role pins
    output logic             o_ready_irq,
    output logic             o_wait_io_transfer_ready,
    output logic             o_input_ack_dma_request,
    output logic             o_input_ack_dma_request_oe,
    // Drive handshake pins
    input  wire logic        i_diag_pass_n,
    output logic             o_diag_pass_n,
    output logic             o_diag_pass_n_oe,
    input  wire logic        i_drive_active_second_present_n,
    output logic             o_drive_active_second_present_n,
    output logic             o_drive_active_second_present_n_oe,
    // Card core side
    input  wire logic        i_io_configured,
    input  wire logic        i_status_alert_enable,
    input  wire logic        i_card_ready,
    input  wire logic        i_write_protect,
    input  wire logic        i_irq_pending,
    input  wire logic        i_core_wait,
    input  wire logic        i_diag_passed,
    input  wire logic        i_drive_active,
    input  wire logic        i_dma_data_ready,
    input  wire logic        i_status_change_clear,
    input  wire logic [15:0] i_reg_rdata,
    output logic       [2:0] o_reg_space,
    output logic      [10:0] o_reg_index,
    output logic             o_reg_rd,
    output logic             o_reg_wr,
    output logic             o_reg_wide,
    output logic      [15:0] o_reg_wdata,
    output logic             o_is_secondary,
    output logic             o_peer_diag_passed,
    output logic             o_peer_present,
    output logic             o_dma_xfer,
    output logic             o_fixed_disk,
    output logic       [2:0] o_pio_mode_max,
    output logic             o_dma_supported,
    output logic       [2:0] o_dma_mode_max
);

    card_decode_if          dec_bus ();
    card_pin_pkg::mode_e    mode;
    card_pin_pkg::mode_e    next_mode;
    logic                   strap_done;
    logic                   disk_strap;
    logic                   next_disk_strap;
    logic                   secondary;
    logic                   next_secondary;
    card_pin_pkg::dma_e     dma_state;
    card_pin_pkg::dma_e     next_dma_state;
    logic                   ready_q;
    logic                   protect_q;
    logic                   alert_pend;
    logic                   next_alert_pend;
    logic [15:0]            rdata;
    logic [15:0]            next_rdata;
    logic                   dma_ack;

    // ------------------------------------------------------------------
    // Mode strap and decoder
    // ------------------------------------------------------------------
    always_comb begin
        next_disk_strap = strap_done ? disk_strap : !i_disk_mode_select_n;
        next_secondary  = strap_done ? secondary
                                     : i_primary_secondary_select_n;
        if (disk_strap) begin
            next_mode = card_pin_pkg::MODE_DISK;
        end else if (i_io_configured) begin
            next_mode = card_pin_pkg::MODE_IO;
        end else begin
            next_mode = card_pin_pkg::MODE_MEM;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            strap_done <= 1'b0;
            disk_strap <= 1'b0;
            secondary  <= 1'b0;
            mode       <= card_pin_pkg::MODE_MEM;
        end else begin
            strap_done <= 1'b1;
            disk_strap <= next_disk_strap;
            secondary  <= next_secondary;
            mode       <= next_mode;
        end
    end

    assign dec_bus.mode        = mode;
    assign dec_bus.addr        = i_addr;
    assign dec_bus.first_sel_n = i_command_block_select_n;
    assign dec_bus.odd_sel_n   = i_odd_byte_enable_n;
    assign dec_bus.attr_n      = i_attr_dma_acknowledge_n;
    assign dec_bus.oe_n        = i_output_enable_n;
    assign dec_bus.we_n        = i_write_enable_n;
    assign dec_bus.iord_n      = i_io_read_n;
    assign dec_bus.iowr_n      = i_io_write_n;
    assign dec_bus.dma_active  = dma_state == card_pin_pkg::DMA_XFER;

    card_addr_decode u_decode (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .bus        (dec_bus.dec)
    );

    // ------------------------------------------------------------------
    // DMA handshake and status alert
    // ------------------------------------------------------------------
    // Acknowledge seen only while a DMA is under way
    assign dma_ack = (dma_state != card_pin_pkg::DMA_IDLE)
                   && !i_attr_dma_acknowledge_n;

    always_comb begin
        next_dma_state = dma_state;
        unique case (dma_state)
            card_pin_pkg::DMA_IDLE: begin
                if (DMA_SUPPORTED && mode == card_pin_pkg::MODE_DISK
                    && i_dma_data_ready) begin
                    next_dma_state = card_pin_pkg::DMA_REQ;
                end
            end
            card_pin_pkg::DMA_REQ: begin
                if (dma_ack) begin
                    next_dma_state = card_pin_pkg::DMA_XFER;
                end
            end
            card_pin_pkg::DMA_XFER: begin
                if (!dma_ack) begin
                    next_dma_state = i_dma_data_ready
                                   ? card_pin_pkg::DMA_REQ
                                   : card_pin_pkg::DMA_IDLE;
                end
            end
            default: next_dma_state = card_pin_pkg::DMA_IDLE;
        endcase
        // New change wins over a clear in the same cycle
        next_alert_pend = alert_pend && !i_status_change_clear;
        if (ready_q != i_card_ready || protect_q != i_write_protect) begin
            next_alert_pend = 1'b1;
        end
        next_rdata = rdata;
        if (dec_bus.rd) begin
            next_rdata = i_reg_rdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            dma_state  <= card_pin_pkg::DMA_IDLE;
            ready_q    <= i_card_ready;
            protect_q  <= i_write_protect;
            alert_pend <= 1'b0;
            rdata      <= '0;
        end else begin
            dma_state  <= next_dma_state;
            ready_q    <= i_card_ready;
            protect_q  <= i_write_protect;
            alert_pend <= next_alert_pend;
            rdata      <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Pin roles
    // ------------------------------------------------------------------
    always_comb begin
        o_battery_detect_first  = card_pin_pkg::BATTERY_LEVEL;
        o_battery_detect_second = card_pin_pkg::BATTERY_LEVEL;
        o_audio_out_n           = card_pin_pkg::AUDIO_NEGATED;
        o_status_change_alert_n = card_pin_pkg::BATTERY_LEVEL;
        if (mode == card_pin_pkg::MODE_IO) begin
            o_battery_detect_first  = !(i_status_alert_enable
                                        && alert_pend);
            o_status_change_alert_n = o_battery_detect_first;
        end
        o_insert_detect_first_n  = card_pin_pkg::DETECT_LEVEL;
        o_insert_detect_second_n = card_pin_pkg::DETECT_LEVEL;
        o_input_ack_dma_request_oe = 1'b1;
        o_ready_irq                = 1'b0;
        o_input_ack_dma_request    = 1'b1;
        unique case (mode)
            card_pin_pkg::MODE_MEM: begin
                o_ready_irq             = i_card_ready;
                o_input_ack_dma_request = 1'b1;
            end
            card_pin_pkg::MODE_IO: begin
                o_ready_irq             = !i_irq_pending;
                o_input_ack_dma_request = !(dec_bus.rd &&
                    dec_bus.space == card_pin_pkg::SPACE_IOPORT);
            end
            card_pin_pkg::MODE_DISK: begin
                o_ready_irq             = i_irq_pending;
                o_input_ack_dma_request =
                    dma_state == card_pin_pkg::DMA_REQ;
                o_input_ack_dma_request_oe = DMA_SUPPORTED;
            end
        endcase
        o_wait_io_transfer_ready = !i_core_wait;
    end

    // Open-drain drive handshake, disk mode only
    assign o_diag_pass_n     = 1'b0;
    assign o_diag_pass_n_oe  = mode == card_pin_pkg::MODE_DISK
                             && secondary && i_diag_passed;
    assign o_drive_active_second_present_n = 1'b0;
    assign o_drive_active_second_present_n_oe =
        mode == card_pin_pkg::MODE_DISK
        && (i_drive_active || secondary);
    assign o_peer_diag_passed = mode == card_pin_pkg::MODE_DISK
                              && !i_diag_pass_n;
    assign o_peer_present     = mode == card_pin_pkg::MODE_DISK
                              && !i_drive_active_second_present_n;
    // Select input only matters in disk mode
    assign o_is_secondary = mode == card_pin_pkg::MODE_DISK
                          && secondary;

    assign o_data         = rdata;
    assign o_data_low_oe  = dec_bus.rd;
    assign o_data_high_oe = dec_bus.rd && dec_bus.wide;
    assign o_reg_space    = dec_bus.space;
    assign o_reg_index    = dec_bus.index;
    assign o_reg_rd       = dec_bus.rd;
    assign o_reg_wr       = dec_bus.wr;
    assign o_reg_wide     = dec_bus.wide;
    // Undriven upper lane masked off on narrow writes
    assign o_reg_wdata    = dec_bus.wide ? i_data : {8'h00, i_data[7:0]};
    assign o_dma_xfer     = dec_bus.dma_active;
    assign o_fixed_disk   = mode == card_pin_pkg::MODE_DISK;
    assign o_pio_mode_max = card_pin_pkg::PIO_MODE_MAX;
    assign o_dma_supported = DMA_SUPPORTED;
    assign o_dma_mode_max = DMA_SUPPORTED ? card_pin_pkg::DMA_MODE_MAX
                                          : 3'h0;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    AST_DISK_IDX: assert property (mode == card_pin_pkg::MODE_DISK ##1
        (mode == card_pin_pkg::MODE_DISK) |-> o_reg_index[10:3] == 8'h00)
        else $error("disk index uses high address bits");
    AST_BATTERY: assert property (mode == card_pin_pkg::MODE_MEM |->
        o_battery_detect_first && o_battery_detect_second)
        else $error("battery detect not high");
    AST_ALERT: assert property ((mode == card_pin_pkg::MODE_IO &&
        i_status_alert_enable && !i_status_change_clear &&
        $changed(i_card_ready)) ##1 (mode == card_pin_pkg::MODE_IO &&
        i_status_alert_enable) |-> !o_status_change_alert_n)
        else $error("status alert missed a change");
    AST_AUDIO: assert property (o_audio_out_n)
        else $error("audio pin asserted");
    AST_DETECT: assert property (!o_insert_detect_first_n &&
        !o_insert_detect_second_n)
        else $error("insert detect not low");
    AST_NO_DMA_IDLE: assert property (dma_state == card_pin_pkg::DMA_IDLE
        && !i_dma_data_ready |=> dma_state == card_pin_pkg::DMA_IDLE)
        else $error("acknowledge acted without DMA");
    AST_DMA_REQUEST_HOLD: assert property (dma_state == card_pin_pkg::DMA_REQ &&
        i_attr_dma_acknowledge_n |=> o_input_ack_dma_request)
        else $error("request dropped before acknowledge");
    AST_DMA_REQUEST_DROP: assert property (dma_state == card_pin_pkg::DMA_REQ &&
        !i_attr_dma_acknowledge_n |=> !o_input_ack_dma_request)
        else $error("request kept after acknowledge");
    AST_IRQ_HIGH: assert property (mode == card_pin_pkg::MODE_DISK &&
        i_irq_pending |-> o_ready_irq)
        else $error("disk interrupt not active high");
    AST_FIXED: assert property (strap_done |=>
        o_fixed_disk == disk_strap)
        else $error("disk type flag wrong");
    AST_DMA_MODES: assert property (o_dma_mode_max ==
        (DMA_SUPPORTED ? 3'h4 : 3'h0) && o_pio_mode_max == 3'h6)
        else $error("transfer mode limits wrong");

    COV_DMA: cover property (dma_state == card_pin_pkg::DMA_REQ ##1
        dma_state == card_pin_pkg::DMA_XFER ##1
        dma_state == card_pin_pkg::DMA_REQ);
    COV_ALERT: cover property (!o_status_change_alert_n);
    COV_CTRL: cover property (o_reg_space == card_pin_pkg::SPACE_CTRL);
    COV_CONFIG: cover property (o_reg_space == card_pin_pkg::SPACE_CONFIG);

endmodule : storage_card_host_pin_interface

// *** tb_storage_card_host_pin_interface.sv ***
// Bench for the card host pin interface
`timescale 1ns/1ps
module tb_storage_card_host_pin_interface;
    logic i_core_clk = '0, i_reset = '1, i_disk_mode_select_n = '0;
    logic i_command_block_select_n = '1, i_odd_byte_enable_n = '1;
    logic i_output_enable_n = '1, i_io_read_n = '1, i_io_write_n = '1;
    logic i_write_enable_n = '1, i_primary_secondary_select_n = '0;
    logic i_io_configured = '0, i_status_alert_enable = '0, i_card_ready = '0;
    logic i_write_protect = '0, i_irq_pending = '0, i_core_wait = '0;
    logic i_diag_passed = '0, i_drive_active = '0, i_dma_data_ready = '0;
    logic i_status_change_clear = '0, tb_ack_n = '1, use_model = '0;
    logic slow = '0;
    logic [10:0] i_addr = '0, o_reg_index;
    logic [15:0] i_data = '0, i_reg_rdata = '0, o_data, o_reg_wdata;
    logic [2:0]  o_reg_space, o_pio_mode_max, o_dma_mode_max;
    logic o_data_low_oe, o_data_high_oe, o_battery_detect_first, o_reg_rd;
    logic o_battery_detect_second, o_status_change_alert_n, o_audio_out_n;
    logic o_insert_detect_first_n, o_insert_detect_second_n, o_ready_irq;
    logic o_wait_io_transfer_ready, o_input_ack_dma_request, o_reg_wr;
    logic o_input_ack_dma_request_oe, o_diag_pass_n, o_diag_pass_n_oe;
    logic o_drive_active_second_present_n, o_is_secondary, o_reg_wide;
    logic o_drive_active_second_present_n_oe, o_peer_diag_passed, model_ack_n;
    logic o_peer_present, o_dma_xfer, o_fixed_disk, o_dma_supported;
    logic i_attr_dma_acknowledge_n, i_diag_pass_n;
    logic i_drive_active_second_present_n;
    logic [31:0] seed = 32'h25;
    int err_count = 0;
    int n_checks = 0;
    always #2 i_core_clk = ~i_core_clk;
    assign i_attr_dma_acknowledge_n = use_model ? model_ack_n : tb_ack_n;
    assign i_diag_pass_n = !(o_diag_pass_n_oe && !o_diag_pass_n);
    assign i_drive_active_second_present_n =
        !(o_drive_active_second_present_n_oe && !o_drive_active_second_present_n);
    storage_card_host_pin_interface #(.DMA_SUPPORTED(1'b1)) u_dut (.*);
    host_dma_model u_host (.i_core_clk(i_core_clk), .i_slow(slow),
        .i_dma_request(o_input_ack_dma_request),
        .o_dma_acknowledge_n(model_ack_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] exp_index(input logic [10:0] a);
        return {13'h0, a[2:0]};
    endfunction : exp_index
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        cyc(6);
        i_reset = '0;
        cyc(3);
        chk(o_insert_detect_first_n, 16'h0);
        chk(o_insert_detect_second_n, 16'h0);
        chk(o_fixed_disk, 16'h1);
        chk(o_pio_mode_max, 16'h6);
        chk(o_dma_mode_max, 16'h4);
        for (int i = 0; i < 9; i++) begin
            void'(rnd());
            i_addr = {8'h00, i[2:0]};
            {i_irq_pending, i_core_wait} = seed[12:11];
            i_write_enable_n = '1;
            {i_diag_passed, i_drive_active, i_output_enable_n} = seed[16:14];
            {i_data, i_reg_rdata} = {seed[31:16], seed[15:0]};
            i_command_block_select_n = i[3];
            i_odd_byte_enable_n = !i[3];
            i_io_read_n = '0;
            cyc(3);
            chk(o_reg_space, i[3] ? card_pin_pkg::SPACE_CTRL
                                  : card_pin_pkg::SPACE_TASK);
            if (!i[3]) chk(o_reg_index, exp_index(i_addr));
            chk(o_reg_wr, 16'h0);
            chk(o_ready_irq, i_irq_pending);
            chk(o_wait_io_transfer_ready, !i_core_wait);
            chk(o_reg_wdata, {8'h00, i_data[7:0]});
            chk(o_data_high_oe, 16'h0);
            chk(o_peer_present, i_drive_active);
            chk(o_diag_pass_n_oe, 16'h0);
            {i_command_block_select_n, i_odd_byte_enable_n, i_io_read_n} = '1;
            cyc(1);
        end
        tb_ack_n = '0;
        cyc(3);
        chk(o_input_ack_dma_request, 16'h0);
        chk(o_dma_xfer, 16'h0);
        use_model = '1;
        for (int j = 0; j < 2; j++) begin
            slow = j[0];
            i_dma_data_ready = '1;
            for (int k = 0; k < 12 && !o_dma_xfer; k++) cyc(1);
            chk(o_dma_xfer, 16'h1);
            chk(o_input_ack_dma_request, 16'h0);
            i_dma_data_ready = j[0];
            cyc(1);
            chk(o_input_ack_dma_request, j[0]);
            i_dma_data_ready = '0;
            cyc(8);
            chk(o_input_ack_dma_request, 16'h0);
        end
        use_model = '0;
        i_reset = '1;
        i_disk_mode_select_n = '1;
        i_primary_secondary_select_n = '1;
        cyc(6);
        i_reset = '0;
        i_card_ready = '1;
        cyc(3);
        chk(o_battery_detect_first, 16'h1);
        chk(o_battery_detect_second, 16'h1);
        chk(o_fixed_disk, 16'h0);
        chk(o_ready_irq, 16'h1);
        {i_io_configured, i_status_alert_enable} = '1;
        cyc(4);
        chk(o_audio_out_n, 16'h1);
        i_status_change_clear = '1;
        cyc(1);
        i_status_change_clear = '0;
        cyc(1);
        chk(o_status_change_alert_n, 16'h1);
        i_write_protect = '1;
        cyc(4);
        chk(o_status_change_alert_n, 16'h0);
        void'(rnd());
        i_addr = seed[10:0];
        {i_command_block_select_n, i_output_enable_n} = '0;
        cyc(2);
        chk(o_reg_space, (i_addr >= card_pin_pkg::CONFIG_BASE)
            ? card_pin_pkg::SPACE_CONFIG : card_pin_pkg::SPACE_CIS);
        chk(o_reg_index, i_addr);
        {tb_ack_n, i_output_enable_n, i_io_read_n} = 3'b110;
        cyc(2);
        chk(o_reg_space, card_pin_pkg::SPACE_IOPORT);
        chk(o_input_ack_dma_request, 16'h0);
        chk(o_is_secondary, 16'h0);
        tally_and_finish();
    end
endmodule : tb_storage_card_host_pin_interface
